/* rtl/iadc_regs.sv */
// Own address, high-speed code and data command port registers on APB
// How it works
// R1: Keep a 10-bit own slave address for slave address matching.
// R2: With 7-bit addressing compare only the low seven address bits.
// R3: Address and code registers take writes only while the controller is disabled.
// R4: Software must avoid reserved bus addresses 0x00-0x07 and 0x78-0x7f.
// R5: Own address resets to its build parameter, 0x55 here.
// R6: Three-bit code forms the low bits of the 00001xxx high-speed code.
// R7: High-speed code resets to its build parameter, 0x1 here.
// R8: Below high speed the code register is read-only and reads zero.
// R9: Port write pushes one transmit entry; port read pops one received byte.
// R10: Transmit entries are nine bits; received bytes are eight bits.
// R11: Entry bit 8 selects write (0) or read (1); resets to 0.
// R12: Command bit steers direction only when acting as master.
// R13: As slave receiver port writes are not needed; command is don't-care.
// R14: As slave transmitter a write entry sends its low byte.
// R15: Read entry after general call with special still set raises transmit abort.
// R16: Read entry queued after a read request raises transmit abort.
// R17: Master read clashing with a read request is dropped with abort.
// R18: A read entry ignores its low data byte.
// R19: Port reads return the received bus byte in the low byte.
// R20: Control bit 3 picks 7-bit or 10-bit matching; 7-bit ignores 10-bit.
// R21: Special bit clear means general call selection is ignored.
// R22: Reading an empty receive FIFO returns zero and pops nothing.
`timescale 1ns/1ps
`default_nettype none

module iadc_regs
  import iadc_pkg::*;
#(
  parameter logic [9:0] default_own_address_param = IADC_OWN_ADDR_RST,
  parameter logic [2:0] default_hs_code_param = IADC_HS_CODE_RST,
  parameter logic [1:0] top_speed_setting = IADC_TOP_SPEED_RST
) (
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  // Controller state from the rest of the unit
  input wire logic controller_enable,
  input wire logic master_active,
  input wire logic slave_transmitter,
  input wire logic own_wide_addressing,
  input wire logic special_command,
  input wire logic general_call_or_start_byte,
  input wire logic read_request_pending,
  // Transmit FIFO push side
  output logic tx_valid,
  input wire logic tx_ready,
  output iadc_entry_t tx_entry,
  // Receive FIFO pop side
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_pop,
  // Slave address matching
  input wire iadc_bus_addr_t bus_addr,
  output logic addr_match,
  // Outputs towards the bus engine
  output logic [9:0] own_address_field,
  output logic [7:0] hs_master_code,
  output logic transmit_abort
);

  iadc_state_t state_reg;
  iadc_state_t state_next;

  logic setup_phase;
  logic access_phase;
  logic sel_own;
  logic sel_hs;
  logic sel_data;
  logic hs_present;
  logic abort_cond;
  logic data_write;
  logic tx_stall;

  // High-speed code only exists when the part is built for high speed
  function automatic logic hs_available(input logic [1:0] speed);
    hs_available = (speed == IADC_SPEED_HIGH);
  endfunction : hs_available

  // Own address compare; 7-bit mode looks at the low bits only
  function automatic logic own_match(input iadc_bus_addr_t a, input logic wide,
                                     input logic [9:0] own);
    if (!a.check) begin
      own_match = 1'b0;
    end else if (wide) begin
      own_match = a.wide && (a.addr == own); // R1 R20
    end else begin
      own_match = !a.wide && (a.addr[6:0] == own[6:0]); // R2 R20
    end
  endfunction : own_match

  // Bus phase and address decode
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign sel_own = (paddr == IADC_OWN_SLAVE_ADDRESS_OFF);
  assign sel_hs = (paddr == IADC_HIGH_SPEED_MASTER_CODE_OFF);
  assign sel_data = (paddr == IADC_DATA_COMMAND_PORT_OFF);
  assign hs_present = hs_available(top_speed_setting);
  assign data_write = access_phase && pwrite && sel_data;

  // Read entries that clash with a read request or a live general call are dropped
  always_comb begin
    abort_cond = 1'b0;
    if (pwdata[IADC_CMD_BIT] == IADC_CMD_READ) begin
      if (read_request_pending) begin
        abort_cond = 1'b1; // R16 R17
      end
      if (special_command && !general_call_or_start_byte) begin
        abort_cond = 1'b1; // R15 R21
      end
    end
  end

  // Hold the access phase while the transmit FIFO cannot take the entry
  assign tx_stall = data_write && !abort_cond && !tx_ready;
  assign pready = !tx_stall;

  // Push is a handshake; the entry itself comes from a flop set in setup
  assign tx_valid = data_write && !abort_cond; // R9
  // Pop only when a byte is there, so an empty read leaves the FIFO alone
  assign rx_pop = setup_phase && !pwrite && sel_data && rx_valid; // R9 R22

  // Next-state logic for every register of the block
  always_comb begin
    state_next = state_reg;
    state_next.transmit_abort = 1'b0;
    state_next.addr_match = own_match(bus_addr, own_wide_addressing,
                                      state_reg.own_address_field);

    // Capture the entry during setup; APB holds pwdata through access
    if (setup_phase && pwrite && sel_data) begin
      state_next.tx_entry.cmd = pwdata[IADC_CMD_BIT]; // R10 R11 R12
      if (pwdata[IADC_CMD_BIT] == IADC_CMD_READ) begin
        state_next.tx_entry.dat = 8'h00; // R18
      end else begin
        state_next.tx_entry.dat = pwdata[7:0]; // R14
      end
    end

    // Read data is registered in setup and shown in access
    if (setup_phase && !pwrite) begin
      state_next.prdata = 32'h0000_0000;
      if (sel_own) begin
        state_next.prdata[9:0] = state_reg.own_address_field;
      end else if (sel_hs && hs_present) begin
        state_next.prdata[2:0] = state_reg.hs_code_field;
      end else if (sel_data && rx_valid) begin
        state_next.prdata[7:0] = rx_data; // R10 R19
      end
    end

    // Configuration writes are locked while the controller runs
    if (access_phase && pwrite && !controller_enable) begin
      if (sel_own) begin
        state_next.own_address_field = pwdata[9:0]; // R3 R4
      end
      if (sel_hs && hs_present) begin
        state_next.hs_code_field = pwdata[2:0]; // R3 R8
      end
    end

    // A refused read entry flags transmit abort for one cycle
    if (data_write && abort_cond) begin
      state_next.transmit_abort = 1'b1; // R15 R16 R17
    end
  end

  // State register with synchronous reset to the build values
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg.own_address_field <= default_own_address_param; // R5
      state_reg.hs_code_field <= default_hs_code_param; // R7
      state_reg.prdata <= 32'h0000_0000;
      state_reg.tx_entry.cmd <= IADC_CMD_RST; // R11
      state_reg.tx_entry.dat <= 8'h00;
      state_reg.transmit_abort <= 1'b0;
      state_reg.addr_match <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs; slave receive needs no entries so nothing here waits on them
  assign prdata = state_reg.prdata;
  assign tx_entry = state_reg.tx_entry; // R13
  assign addr_match = state_reg.addr_match;
  assign own_address_field = state_reg.own_address_field;
  // Code pattern 00001xxx; zero when the register does not exist
  assign hs_master_code = hs_present ? {IADC_HS_PREFIX, state_reg.hs_code_field}
                                     : 8'h00; // R6 R8
  assign transmit_abort = state_reg.transmit_abort;

  // Master and slave-transmitter status only steer the bus engine
  logic unused_mode;
  assign unused_mode = master_active ^ slave_transmitter ^ (^pwdata[31:9]);

endmodule : iadc_regs

`default_nettype wire

/* rtl/iadc_pkg.sv */
// Package of offsets, reset values and carriers for the address and data command registers
package iadc_pkg;

  // Register byte offsets on the APB port
  localparam logic [7:0] IADC_OWN_SLAVE_ADDRESS_OFF = 8'h08;
  localparam logic [7:0] IADC_HIGH_SPEED_MASTER_CODE_OFF = 8'h0c;
  localparam logic [7:0] IADC_DATA_COMMAND_PORT_OFF = 8'h10;

  // Field positions and widths
  localparam int IADC_OWN_ADDR_W = 10;
  localparam int IADC_SHORT_ADDR_W = 7;
  localparam int IADC_HS_CODE_W = 3;
  localparam int IADC_CMD_BIT = 8;
  localparam int IADC_ENTRY_W = 9;
  localparam int IADC_BYTE_W = 8;

  // Values after reset
  localparam logic [9:0] IADC_OWN_ADDR_RST = 10'h055;
  localparam logic [2:0] IADC_HS_CODE_RST = 3'h1;
  localparam logic [1:0] IADC_TOP_SPEED_RST = 2'h3;
  localparam logic IADC_CMD_RST = 1'h0;

  // Top speed settings and the high-speed code prefix
  localparam logic [1:0] IADC_SPEED_STANDARD = 2'h1;
  localparam logic [1:0] IADC_SPEED_FAST = 2'h2;
  localparam logic [1:0] IADC_SPEED_HIGH = 2'h3;
  localparam logic [4:0] IADC_HS_PREFIX = 5'h01;

  // Command bit encodings of a queued entry
  localparam logic IADC_CMD_WRITE = 1'h0;
  localparam logic IADC_CMD_READ = 1'h1;

  // One queued transmit entry
  typedef struct packed {
    logic cmd;
    logic [7:0] dat;
  } iadc_entry_t;

  // Address seen on the bus by the slave side
  typedef struct packed {
    logic check;
    logic wide;
    logic [9:0] addr;
  } iadc_bus_addr_t;

  // All state of the block
  typedef struct packed {
    logic [9:0] own_address_field;
    logic [2:0] hs_code_field;
    logic [31:0] prdata;
    iadc_entry_t tx_entry;
    logic transmit_abort;
    logic addr_match;
  } iadc_state_t;

endpackage : iadc_pkg

/* sim/iadc_regs_asserts.sv */
// Port assertions for the register block
`timescale 1ns/1ps
`default_nettype none
module iadc_regs_asserts import iadc_pkg::*; (
  input wire logic clk, rst_n, psel, penable, pwrite, controller_enable, read_request_pending,
  input wire logic tx_valid, rx_valid, rx_pop, transmit_abort,
  input wire logic [7:0] paddr, rx_data, hs_master_code,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [9:0] own_address_field,
  input wire iadc_entry_t tx_entry,
  input wire logic addr_match, own_wide_addressing,
  input wire iadc_bus_addr_t bus_addr);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Write access phases, the causes behind stored values
  wire logic ao = psel && penable && pwrite && paddr == 8'h08;
  wire logic ad = psel && penable && pwrite && paddr == 8'h10;
  AST_OWN_LOCK: assert property (ao && controller_enable |=> $stable(own_address_field))
    else $error("own lock");
  AST_OWN_WRITE: assert property (ao && !controller_enable |=>
    own_address_field == $past(pwdata[9:0])) else $error("own write");
  AST_HS_PREFIX: assert property (hs_master_code[7:3] == 5'h01) else $error("prefix");
  AST_POP: assert property (rx_pop |-> rx_valid && psel && !penable && !pwrite)
    else $error("pop");
  AST_RX: assert property (rx_pop |=> prdata == {24'h0, $past(rx_data)})
    else $error("rx");
  AST_PUSH: assert property (ad && !pwdata[8] |-> tx_valid && tx_entry == pwdata[8:0])
    else $error("push");
  AST_READ_ENTRY: assert property (tx_valid && tx_entry.cmd |-> tx_entry.dat == 8'h00)
    else $error("read entry");
  AST_MATCH7: assert property (bus_addr.check && !bus_addr.wide && !own_wide_addressing |=>
    addr_match == ($past(bus_addr.addr[6:0]) == $past(own_address_field[6:0])))
    else $error("short match");
  AST_IGNORE10: assert property (bus_addr.check && bus_addr.wide && !own_wide_addressing |=>
    !addr_match) else $error("wide ignored");
  AST_ABORT: assert property (ad && pwdata[8] && read_request_pending |->
    !tx_valid ##1 transmit_abort ##1 !transmit_abort) else $error("abort");
endmodule : iadc_regs_asserts
bind iadc_regs iadc_regs_asserts iadc_regs_asserts_i (.*);
`default_nettype wire

/* sim/iadc_fifo_model.sv */
// Stand-in for the FIFOs behind the block
`timescale 1ns/1ps
`default_nettype none
module iadc_fifo_model import iadc_pkg::*; (
  input wire logic clk, stall, tx_valid, rx_pop,
  input wire iadc_entry_t tx_entry,
  output logic tx_ready, rx_valid,
  output logic [7:0] rx_data,
  output iadc_entry_t last_push,
  output logic [3:0] n_push);
  logic left = 1'h1;
  initial n_push = 4'h0;
  // One byte queued; once empty the head shows its inverse, not a stale copy
  assign rx_valid = left;
  assign rx_data = left ? 8'ha7 : 8'h58;
  assign tx_ready = !stall;
  // Takes whole nine-bit entries
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      last_push <= tx_entry;
      n_push <= n_push + 4'h1;
    end
    if (rx_pop) left <= 1'h0;
  end
endmodule : iadc_fifo_model
`default_nettype wire

/* sim/tb_iadc_regs.sv */
// Self-checking bench for the register block
`timescale 1ns/1ps
`default_nettype none
module tb_iadc_regs import iadc_pkg::*;;
  logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, stall = 1'h0;
  logic controller_enable = 1'h0, read_request_pending = 1'h0, special_command = 1'h0;
  logic general_call_or_start_byte = 1'h0, master_active = 1'h0, slave_transmitter = 1'h0;
  logic own_wide_addressing = 1'h0, ab, pready, tx_valid, tx_ready, rx_valid, rx_pop;
  logic addr_match, transmit_abort;
  logic [7:0] paddr = 8'h00, rx_data, hs_master_code;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [9:0] own_address_field;
  logic [3:0] n_push;
  iadc_entry_t tx_entry, last_push;
  iadc_bus_addr_t bus_addr = '0;
  int n_fail = 0, comparisons = 0;
  iadc_regs iadc_regs_i (.*);
  iadc_fifo_model iadc_fifo_model_i (.*);
  always #25 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) n_fail++;
    if (g !== e) $display("wrong value %s exp %h got %h", nm, e, g);
  endtask : chk
  // Request held until pready is sampled high; an idle edge first
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge clk);
    #1 {psel, pwrite, paddr, pwdata} = {1'h1, w, a, d};
    @(posedge clk);
    #1 penable = 1'h1;
    // Ready is judged at the very edge that ends the access, never after it
    @(posedge clk);
    while (pready !== 1'h1 && k < 40) begin
      k++;
      @(posedge clk);
    end
    if (k >= 40) n_fail++;
    #1 {q, ab, psel, penable} = {prdata, transmit_abort, 2'h0};
  endtask : apb
  task automatic t_own();
    apb(1'h0, 8'h08, 32'h0);
    chk("own", 32'h55, q);
    controller_enable = 1'h1;
    apb(1'h1, 8'h08, 32'h2a3);
    apb(1'h1, 8'h0c, 32'h5);
    chk("own", 32'h55, {22'h0, own_address_field});
    chk("hs", 32'h09, {24'h0, hs_master_code});
    controller_enable = 1'h0;
    apb(1'h1, 8'h08, 32'h2a3);
    apb(1'h1, 8'h0c, 32'h5);
    apb(1'h0, 8'h0c, 32'h0);
    chk("hs", 32'h5, q);
    chk("own", 32'h2a3, {22'h0, own_address_field});
    chk("hs", 32'h0d, {24'h0, hs_master_code});
  endtask : t_own
  task automatic t_fifo();
    logic [3:0] n0;
    n0 = n_push;
    stall = 1'h1;
    fork #200 stall = 1'h0; join_none
    apb(1'h1, 8'h10, 32'h1a5);
    chk("entry", 32'h100, {23'h0, last_push});
    apb(1'h1, 8'h10, 32'h03c);
    chk("entry", 32'h03c, {23'h0, last_push});
    chk("pushes", 32'h2, {28'h0, n_push - n0});
    apb(1'h0, 8'h10, 32'h0);
    chk("rx", 32'ha7, q);
    apb(1'h0, 8'h10, 32'h0);
    chk("rx", 32'h0, q);
  endtask : t_fifo
  task automatic t_abort();
    logic [3:0] n0;
    n0 = n_push;
    read_request_pending = 1'h1;
    apb(1'h1, 8'h10, 32'h1ff);
    chk("abort", 32'h1, {31'h0, ab});
    read_request_pending = 1'h0;
    special_command = 1'h1;
    apb(1'h1, 8'h10, 32'h100);
    chk("abort", 32'h1, {31'h0, ab});
    special_command = 1'h0;
    chk("pushes", 32'h0, {28'h0, n_push - n0});
  endtask : t_abort
  task automatic t_match();
    bus_addr = {1'h1, 1'h0, 10'h123};
    @(posedge clk);
    #1 chk("match", 32'h1, {31'h0, addr_match});
    bus_addr = {1'h1, 1'h1, 10'h2a3};
    @(posedge clk);
    #1 chk("match", 32'h0, {31'h0, addr_match});
    own_wide_addressing = 1'h1;
    @(posedge clk);
    #1 chk("match", 32'h1, {31'h0, addr_match});
    bus_addr = {1'h1, 1'h1, 10'h123};
    @(posedge clk);
    #1 chk("match", 32'h0, {31'h0, addr_match});
    own_wide_addressing = 1'h0;
    bus_addr = '0;
  endtask : t_match
  task automatic tally_and_finish();
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // Reset for ten cycles, then the scenarios
  initial begin
    repeat (10) @(posedge clk);
    #1 rst_n = 1'h1;
    t_own();
    t_match();
    t_fifo();
    t_abort();
    tally_and_finish();
  end
  // Hang guard, far beyond the fifty or so cycles used
  initial begin
    #60000;
    n_fail++;
    tally_and_finish();
  end
endmodule : tb_iadc_regs
`default_nettype wire
